// [gotr_pkg.sv]
/*
 Package for the rate-sensor correction, spare image and self-test register bank.
 Assumes a byte-wide register port with 8-bit addresses on one 50 MHz clock.
*/
package gotr_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_UNUSED = 8'h35;
    localparam logic [7:0] ADDR_CORR_LOW = 8'h36;
    localparam logic [7:0] ADDR_X_HIGH = 8'h37;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h38;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h39;
    localparam logic [7:0] ADDR_SPARE_LSB = 8'h3A;
    localparam logic [7:0] ADDR_SPARE_BYTE = 8'h3B;
    localparam logic [7:0] ADDR_SELFTEST = 8'h3C;
    // Reset values
    localparam logic [7:0] RST_CORR = 8'h00;
    localparam logic [7:0] RST_SPARE = 8'h00;
    // Self-test register field positions
    localparam int BIT_TRIG = 0;
    localparam int BIT_DONE = 1;
    localparam int BIT_FAIL = 2;
    localparam int BIT_RATE_OK = 4;
    // Self-test run length
    localparam int SELFTEST_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SELFTEST_CYCLES = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Non-volatile write counter width and image layout
    localparam int REMAIN_W = 4;
    localparam int IMAGE_W = 56;
    typedef enum logic [1:0] {
        GOTR_IDLE = 2'b00,
        GOTR_RUN = 2'b01,
        GOTR_DONE = 2'b11
    } gotr_state_type;
endpackage

// [gotr_selftest.sv]
/*
 Self-test sequencer: runs a fixed-length test after a trigger and latches the result.
 Assumes the analogue range verdict is presented as a level during the run.
*/
`timescale 1ns/100ps
module gotr_selftest (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic start,
    input wire logic in_range,
    output logic done,
    output logic fail,
    output logic busy
);
    gotr_pkg::gotr_state_type state_reg, state_next;
    logic [gotr_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic done_reg, done_next, fail_reg, fail_next, bad_reg, bad_next;
    wire logic last_cycle = (cnt_reg == gotr_pkg::CNT_W'(gotr_pkg::SELFTEST_CYCLES - 1));

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        bad_next = bad_reg;
        case (state_reg)
            gotr_pkg::GOTR_IDLE, gotr_pkg::GOTR_DONE: begin
                if (start) begin
                    state_next = gotr_pkg::GOTR_RUN;
                    cnt_next = '0;
                    done_next = 1'b0;
                    fail_next = 1'b0;
                    bad_next = 1'b0;
                end
            end
            gotr_pkg::GOTR_RUN: begin
                cnt_next = cnt_reg + 1'b1;
                bad_next = bad_reg | ~in_range;
                if (last_cycle) begin
                    state_next = gotr_pkg::GOTR_DONE;
                    done_next = 1'b1;
                    fail_next = bad_reg | ~in_range;
                end
            end
            default: state_next = gotr_pkg::GOTR_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_reg <= gotr_pkg::GOTR_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            bad_reg <= bad_next;
        end
    end

    assign done = done_reg;
    assign fail = fail_reg;
    assign busy = (state_reg == gotr_pkg::GOTR_RUN);

    a_result_held: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (state_reg == gotr_pkg::GOTR_DONE) && !start |=> $stable(done_reg) && $stable(fail_reg))
        else $error("Self-test result changed without a new trigger");
    a_done_timing: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (state_reg != gotr_pkg::GOTR_RUN) ##1 (state_reg == gotr_pkg::GOTR_RUN)
        |-> ##50 done_reg)
        else $error("Self-test did not complete in the run time");
    a_fail_cause: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (state_reg == gotr_pkg::GOTR_RUN) && !in_range |=> ##[0:50] (done_reg && fail_reg))
        else $error("Out-of-range run did not report failure");
    c_pass: cover property (@(posedge CORE_CLK) done_reg && !fail_reg);
    c_fail: cover property (@(posedge CORE_CLK) done_reg && fail_reg);
endmodule

// [gotr_regs.sv]
/*
 Register bank for per-axis rate corrections, spare image bytes and self-test control.
 Assumes a byte register port (address, write strobe, read strobe) synchronous to CORE_CLK,
 a non-volatile store presented as a parallel image, and raw rate data from the data path.
*/
`timescale 1ns/100ps
module gotr_regs (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic SOFT_RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic NVM_UNLOCK,
    input wire logic NVM_STORE_TRIG,
    input wire logic NVM_LOAD_TRIG,
    input wire logic NVM_DONE,
    input wire logic [3:0] NVM_REMAIN,
    input wire logic [55:0] NVM_IMAGE_IN,
    output logic [55:0] NVM_IMAGE_OUT,
    output logic NVM_WRITE_REQ,
    output logic NVM_READY,
    input wire logic SENSOR_OK,
    input wire logic SELFTEST_IN_RANGE,
    input wire logic signed [15:0] RATE_X_RAW,
    input wire logic signed [15:0] RATE_Y_RAW,
    input wire logic signed [15:0] RATE_Z_RAW,
    input wire logic signed [15:0] RATE_X_FILT,
    input wire logic signed [15:0] RATE_Y_FILT,
    input wire logic signed [15:0] RATE_Z_FILT,
    output logic signed [15:0] RATE_X_RAW_CORR,
    output logic signed [15:0] RATE_Y_RAW_CORR,
    output logic signed [15:0] RATE_Z_RAW_CORR,
    output logic signed [15:0] RATE_X_FILT_CORR,
    output logic signed [15:0] RATE_Y_FILT_CORR,
    output logic signed [15:0] RATE_Z_FILT_CORR
);
    // Subtract a sign-extended 12-bit correction from a 16-bit rate sample
    function automatic logic signed [15:0] apply_corr(input logic signed [15:0] rate,
                                                       input logic [11:0] corr);
        logic signed [15:0] ext;
        ext = {{4{corr[11]}}, corr};
        apply_corr = rate - ext;
    endfunction

    logic [7:0] low_reg, low_next;
    logic [7:0] xh_reg, xh_next;
    logic [7:0] yh_reg, yh_next;
    logic [7:0] zh_reg, zh_next;
    logic [7:0] spare_lsb_reg, spare_lsb_next;
    logic [7:0] spare_byte_reg, spare_byte_next;
    logic [7:0] rdata_reg, rdata_next;
    logic busy_reg, busy_next;
    logic reload_reg, reload_next;
    logic wreq_reg, ready_reg;
    logic [55:0] image_reg;
    logic st_done, st_fail, st_busy;
    logic signed [15:0] xr_reg, yr_reg, zr_reg, xf_reg, yf_reg, zf_reg;

    // Address decode
    wire logic wr_low = REG_WR && (REG_ADDR == gotr_pkg::ADDR_CORR_LOW);
    wire logic wr_xh = REG_WR && (REG_ADDR == gotr_pkg::ADDR_X_HIGH);
    wire logic wr_yh = REG_WR && (REG_ADDR == gotr_pkg::ADDR_Y_HIGH);
    wire logic wr_zh = REG_WR && (REG_ADDR == gotr_pkg::ADDR_Z_HIGH);
    wire logic wr_spl = REG_WR && (REG_ADDR == gotr_pkg::ADDR_SPARE_LSB);
    wire logic wr_spb = REG_WR && (REG_ADDR == gotr_pkg::ADDR_SPARE_BYTE);
    wire logic wr_st = REG_WR && (REG_ADDR == gotr_pkg::ADDR_SELFTEST);
    wire logic st_start = wr_st && REG_WDATA[gotr_pkg::BIT_TRIG];

    // Store and load acceptance
    wire logic store_ok = NVM_STORE_TRIG && NVM_UNLOCK && !busy_reg
                          && (NVM_REMAIN != 4'h0);
    wire logic load_ok = NVM_LOAD_TRIG && !busy_reg;
    wire logic reload_now = SOFT_RST || reload_reg;

    // Assembled corrections
    wire logic [11:0] corr_x = {xh_reg, low_reg[7:6], spare_lsb_reg[3:2]};
    wire logic [11:0] corr_y = {yh_reg, low_reg[5:3], spare_lsb_reg[1]};
    wire logic [11:0] corr_z = {zh_reg, low_reg[2:0], spare_lsb_reg[0]};

    // Image of all backed registers, current values
    wire logic [55:0] image_now = {spare_byte_reg, spare_lsb_reg, zh_reg, yh_reg, xh_reg,
                                   low_reg, 8'h00};

    // Self-test register view
    wire logic [7:0] st_view = {3'b000, SENSOR_OK, 1'b0, st_fail, st_done, 1'b0};

    // Register next values: reload wins over a host write
    always_comb begin
        low_next = low_reg;
        xh_next = xh_reg;
        yh_next = yh_reg;
        zh_next = zh_reg;
        spare_lsb_next = spare_lsb_reg;
        spare_byte_next = spare_byte_reg;
        if (reload_now) begin
            low_next = NVM_IMAGE_IN[15:8];
            xh_next = NVM_IMAGE_IN[23:16];
            yh_next = NVM_IMAGE_IN[31:24];
            zh_next = NVM_IMAGE_IN[39:32];
            spare_lsb_next = NVM_IMAGE_IN[47:40];
            spare_byte_next = NVM_IMAGE_IN[55:48];
        end else begin
            if (wr_low) low_next = REG_WDATA;
            if (wr_xh) xh_next = REG_WDATA;
            if (wr_yh) yh_next = REG_WDATA;
            if (wr_zh) zh_next = REG_WDATA;
            if (wr_spl) spare_lsb_next = REG_WDATA;
            if (wr_spb) spare_byte_next = REG_WDATA;
        end
    end

    // Non-volatile controller handshake state
    always_comb begin
        busy_next = busy_reg;
        reload_next = 1'b0;
        if (busy_reg && NVM_DONE) begin
            busy_next = 1'b0;
            reload_next = 1'b0;
        end else if (store_ok || load_ok) begin
            busy_next = 1'b1;
        end
        if (load_ok) reload_next = 1'b1;
    end

    // Read multiplexer; unmapped and unused addresses read zero
    always_comb begin
        case (REG_ADDR)
            gotr_pkg::ADDR_CORR_LOW: rdata_next = low_reg;
            gotr_pkg::ADDR_X_HIGH: rdata_next = xh_reg;
            gotr_pkg::ADDR_Y_HIGH: rdata_next = yh_reg;
            gotr_pkg::ADDR_Z_HIGH: rdata_next = zh_reg;
            gotr_pkg::ADDR_SPARE_LSB: rdata_next = spare_lsb_reg;
            gotr_pkg::ADDR_SPARE_BYTE: rdata_next = spare_byte_reg;
            gotr_pkg::ADDR_SELFTEST: rdata_next = st_view;
            default: rdata_next = 8'h00;
        endcase
        if (!REG_RD) rdata_next = rdata_reg;
    end

    // Register storage
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            low_reg <= gotr_pkg::RST_CORR;
            xh_reg <= gotr_pkg::RST_CORR;
            yh_reg <= gotr_pkg::RST_CORR;
            zh_reg <= gotr_pkg::RST_CORR;
            spare_lsb_reg <= gotr_pkg::RST_SPARE;
            spare_byte_reg <= gotr_pkg::RST_SPARE;
            rdata_reg <= 8'h00;
        end else begin
            low_reg <= low_next;
            xh_reg <= xh_next;
            yh_reg <= yh_next;
            zh_reg <= zh_next;
            spare_lsb_reg <= spare_lsb_next;
            spare_byte_reg <= spare_byte_next;
            rdata_reg <= rdata_next;
        end
    end

    // Power-on reload is requested right after system reset releases
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            busy_reg <= 1'b0;
            reload_reg <= 1'b1;
        end else begin
            busy_reg <= busy_next;
            reload_reg <= reload_next;
        end
    end

    // Store request and image capture
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            wreq_reg <= 1'b0;
            ready_reg <= 1'b0;
            image_reg <= '0;
        end else begin
            wreq_reg <= store_ok;
            ready_reg <= !busy_next;
            if (store_ok) image_reg <= image_now;
        end
    end

    // Corrected rate outputs, registered
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            xr_reg <= '0;
            yr_reg <= '0;
            zr_reg <= '0;
            xf_reg <= '0;
            yf_reg <= '0;
            zf_reg <= '0;
        end else begin
            xr_reg <= apply_corr(RATE_X_RAW, corr_x);
            yr_reg <= apply_corr(RATE_Y_RAW, corr_y);
            zr_reg <= apply_corr(RATE_Z_RAW, corr_z);
            xf_reg <= apply_corr(RATE_X_FILT, corr_x);
            yf_reg <= apply_corr(RATE_Y_FILT, corr_y);
            zf_reg <= apply_corr(RATE_Z_FILT, corr_z);
        end
    end

    // Self-test sequencer
    gotr_selftest u_selftest (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .start(st_start),
        .in_range(SELFTEST_IN_RANGE),
        .done(st_done),
        .fail(st_fail),
        .busy(st_busy)
    );

    assign REG_RDATA = rdata_reg;
    assign NVM_IMAGE_OUT = image_reg;
    assign NVM_WRITE_REQ = wreq_reg;
    assign NVM_READY = ready_reg;
    assign RATE_X_RAW_CORR = xr_reg;
    assign RATE_Y_RAW_CORR = yr_reg;
    assign RATE_Z_RAW_CORR = zr_reg;
    assign RATE_X_FILT_CORR = xf_reg;
    assign RATE_Y_FILT_CORR = yf_reg;
    assign RATE_Z_FILT_CORR = zf_reg;

    a_x_assembly: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        1'b1 |=> RATE_X_RAW_CORR == $past(RATE_X_RAW)
            - {{4{$past(xh_reg[7])}}, $past(xh_reg), $past(low_reg[7:6]), $past(spare_lsb_reg[3:2])})
        else $error("X correction not applied");
    a_y_filt: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        1'b1 |=> RATE_Y_FILT_CORR == $past(RATE_Y_FILT) - $signed($past(corr_y)))
        else $error("Y filtered correction wrong");
    a_z_raw: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        1'b1 |=> RATE_Z_RAW_CORR == $past(RATE_Z_RAW) - $signed($past(corr_z)))
        else $error("Z raw correction wrong");
    a_write_direct: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        wr_xh && !reload_now |=> xh_reg == $past(REG_WDATA))
        else $error("Direct write did not take effect");
    a_store_gate: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        NVM_WRITE_REQ |-> $past(NVM_UNLOCK) && $past(NVM_REMAIN) != 4'h0)
        else $error("Store issued while locked or exhausted");
    a_busy_ready: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        busy_reg |-> !NVM_READY)
        else $error("Ready high during an operation");
    a_unused_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        REG_RD && REG_ADDR == gotr_pkg::ADDR_UNUSED |=> REG_RDATA == 8'h00)
        else $error("Unused address read not zero");
    a_rate_flag: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        REG_RD && REG_ADDR == gotr_pkg::ADDR_SELFTEST
        |=> REG_RDATA[gotr_pkg::BIT_RATE_OK] == $past(SENSOR_OK))
        else $error("Healthy flag not reflected");
    c_store: cover property (@(posedge CORE_CLK) NVM_WRITE_REQ);
    c_load: cover property (@(posedge CORE_CLK) load_ok ##[1:20] NVM_READY);
    c_selftest: cover property (@(posedge CORE_CLK) st_start ##1 st_busy ##[1:60] st_done);
endmodule

// [gyro_offset_trim_selftest_regs_test.sv]
/*
 Self-checking bench for the rate-correction register bank, with an integer reference model.
 Assumes the hand-over timing of the bank: registered reads, one-cycle correction latency.
*/
`timescale 1ns/100ps
module gyro_offset_trim_selftest_regs_test;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_rst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic nvm_unlock = 1'b0;
    logic nvm_store = 1'b0;
    logic nvm_load = 1'b0;
    logic nvm_done = 1'b0;
    logic [3:0] nvm_remain = 4'h3;
    logic [55:0] img_in = 56'h0;
    logic [55:0] img_out;
    logic write_req;
    logic ready;
    logic sensor_ok = 1'b1;
    logic in_range = 1'b1;
    logic signed [15:0] r_in [6];
    logic signed [15:0] r_out [6];
    int m [6];
    int n_mismatch = 0;
    int n_tests = 0;

    gotr_regs u_dut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .NVM_UNLOCK(nvm_unlock), .NVM_STORE_TRIG(nvm_store),
        .NVM_LOAD_TRIG(nvm_load), .NVM_DONE(nvm_done), .NVM_REMAIN(nvm_remain),
        .NVM_IMAGE_IN(img_in), .NVM_IMAGE_OUT(img_out), .NVM_WRITE_REQ(write_req),
        .NVM_READY(ready), .SENSOR_OK(sensor_ok), .SELFTEST_IN_RANGE(in_range),
        .RATE_X_RAW(r_in[0]), .RATE_Y_RAW(r_in[1]), .RATE_Z_RAW(r_in[2]),
        .RATE_X_FILT(r_in[3]), .RATE_Y_FILT(r_in[4]), .RATE_Z_FILT(r_in[5]),
        .RATE_X_RAW_CORR(r_out[0]), .RATE_Y_RAW_CORR(r_out[1]), .RATE_Z_RAW_CORR(r_out[2]),
        .RATE_X_FILT_CORR(r_out[3]), .RATE_Y_FILT_CORR(r_out[4]), .RATE_Z_FILT_CORR(r_out[5])
    );

    // Free-running 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then stops the run
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register write; the model follows only mapped backed addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a >= 8'h36 && a <= 8'h3B) m[a - 8'h36] = int'(d);
    endtask

    // Register read; data is registered, so it is taken after the sampling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // One-cycle pulse: 0 store, 1 load, other soft reset
    task automatic pulse(input int kind);
        @(posedge core_clk);
        case (kind)
            0: nvm_store <= 1'b1;
            1: nvm_load <= 1'b1;
            default: soft_rst <= 1'b1;
        endcase
        @(posedge core_clk);
        nvm_store <= 1'b0;
        nvm_load <= 1'b0;
        soft_rst <= 1'b0;
        #1;
    endtask

    task automatic nvm_finish();
        @(posedge core_clk);
        nvm_done <= 1'b1;
        @(posedge core_clk);
        nvm_done <= 1'b0;
        #1;
        chk(ready, 1'b1, "ready after done");
    endtask

    function automatic void load_model();
        foreach (m[i]) m[i] = int'(img_in[8 * i + 8 +: 8]);
    endfunction

    // Assembles a 12-bit correction from the model and makes it signed
    function automatic int corr(input int ax);
        int v;
        case (ax)
            0: v = (m[1] << 4) | (((m[0] >> 6) & 3) << 2) | ((m[4] >> 2) & 3);
            1: v = (m[2] << 4) | (((m[0] >> 3) & 7) << 1) | ((m[4] >> 1) & 1);
            default: v = (m[3] << 4) | ((m[0] & 7) << 1) | (m[4] & 1);
        endcase
        return (v >= 2048) ? v - 4096 : v;
    endfunction

    task automatic check_regs();
        logic [7:0] d;
        for (int a = 8'h35; a <= 8'h3B; a++) begin
            rd(8'(a), d);
            chk(d, (a == 8'h35) ? 8'h00 : 8'(m[a - 8'h36]), "readback");
        end
    endtask

    task automatic check_corr();
        int e;
        @(posedge core_clk);
        foreach (r_in[i]) r_in[i] <= 16'($urandom);
        repeat (2) @(posedge core_clk);
        #1;
        foreach (r_in[i]) begin
            e = int'(r_in[i]) - corr(i % 3);
            chk(r_out[i], 16'(e), "corrected rate");
        end
    endtask

    // Main sequence
    initial begin
        logic [7:0] d;
        int k;
        k = $urandom(59);
        foreach (r_in[i]) r_in[i] = 16'h0000;
        img_in = {24'($urandom), 32'($urandom)};
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        load_model();
        check_regs();
        rd(8'h3C, d);
        chk(d, {3'b000, sensor_ok, 4'h0}, "test flags after reset");
        // Boundary corrections first, then random register contents
        for (int i = 0; i < 6; i++) begin
            for (int a = 0; a < 6; a++) begin
                case (i)
                    0: d = (a == 0 || a == 4) ? 8'h00 : 8'h80;
                    1: d = (a == 0) ? 8'hFF : ((a == 4) ? 8'h0F : 8'h7F);
                    default: d = 8'($urandom);
                endcase
                wr(8'(a + 8'h36), d);
            end
            wr(8'h35, 8'hA5);
            wr(8'h40, 8'h5A);
            check_regs();
            check_corr();
        end
        // Store refused with no writes left, then while locked
        @(posedge core_clk);
        nvm_unlock <= 1'b1;
        nvm_remain <= 4'h0;
        pulse(0);
        chk(write_req, 1'b0, "store with zero count");
        @(posedge core_clk);
        nvm_unlock <= 1'b0;
        nvm_remain <= 4'h3;
        pulse(0);
        chk(write_req, 1'b0, "store while locked");
        @(posedge core_clk);
        nvm_unlock <= 1'b1;
        pulse(0);
        chk(write_req, 1'b1, "store accepted");
        chk(img_out, {8'(m[5]), 8'(m[4]), 8'(m[3]), 8'(m[2]), 8'(m[1]), 8'(m[0]), 8'h00},
            "stored image");
        chk(ready, 1'b0, "ready during store");
        pulse(0);
        chk(write_req, 1'b0, "store while busy");
        nvm_finish();
        // Load trigger and software reset both reload from the image
        for (int kind = 1; kind < 3; kind++) begin
            @(posedge core_clk);
            img_in <= {24'($urandom), 32'($urandom)};
            pulse(kind);
            if (kind == 1) begin
                chk(ready, 1'b0, "ready during load");
                nvm_finish();
            end
            load_model();
            check_regs();
            check_corr();
        end
        // Self-test passing, then failing
        for (int ok = 1; ok >= 0; ok--) begin
            @(posedge core_clk);
            in_range <= 1'(ok);
            sensor_ok <= 1'(ok);
            wr(8'h3C, 8'h01);
            rd(8'h3C, d);
            chk(d[2:1], 2'b00, "flags cleared by trigger");
            k = 0;
            do begin
                rd(8'h3C, d);
                k++;
            end while (d[1] !== 1'b1 && k < 60);
            if (d[1] !== 1'b1) begin
                n_mismatch++;
                $display("CHECK FAILED at %0t: self-test never finished", $time);
                break;
            end
            chk(d, {3'b000, 1'(ok), 1'b0, ~1'(ok), 2'b10}, "test result");
            repeat (10) @(posedge core_clk);
            rd(8'h3C, d);
            chk(d[2:1], {~1'(ok), 1'b1}, "result held");
        end
        print_verdict();
    end
endmodule
